/* rtl/bdm_decoder.sv */
// Purpose: banked data memory: sfr forwarding, nvm control select and general ram
// Assumes: core drives one access per cycle from the same clock; bank pointer held outside
// Notes:   read data returns two edges after the request; sfr reads answer in between
`timescale 1ns/1ps
`default_nettype none
module bdm_decoder #(
  parameter bit VARIANT_LARGE = 1'b0
) (
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_N_IN,
  input  wire logic [bdm_pkg::ADDR_W-1:0]  MEM_ADDR_IN,
  input  wire logic [bdm_pkg::BANK_W-1:0]  BANK_PTR_IN,
  input  wire logic                        MEM_RD_IN,
  input  wire logic                        MEM_WR_IN,
  input  wire logic [bdm_pkg::DATA_W-1:0]  MEM_WDATA_IN,
  input  wire logic [bdm_pkg::DATA_W-1:0]  SFR_RDATA_IN,
  output logic      [bdm_pkg::DATA_W-1:0]  RDATA_OUT,
  output logic                             RDATA_VALID_OUT,
  output logic                             SFR_SEL_OUT,
  output logic                             NVMC_SEL_OUT,
  output logic                             SFR_WR_OUT,
  output logic      [bdm_pkg::ADDR_W-1:0]  SFR_ADDR_OUT,
  output logic      [bdm_pkg::DATA_W-1:0]  SFR_WDATA_OUT
);
  localparam int unsigned DEPTH = VARIANT_LARGE ? bdm_pkg::DEPTH_LARGE : bdm_pkg::DEPTH_SMALL;

  // ram window of one bank; bank 2 exists only in the large variant
  function automatic logic ram_in_bank(input logic [bdm_pkg::ADDR_W-1:0] a,
                                       input logic [bdm_pkg::BANK_W-1:0] b);
    logic hit;
    hit = 1'b0;
    case (b)
      2'h0:    hit = (a >= bdm_pkg::B0_LO) && (a <= bdm_pkg::B0_HI);
      2'h1:    hit = (a >= bdm_pkg::B1_LO) && (a <= bdm_pkg::B1_HI);
      2'h2:    hit = VARIANT_LARGE && (a >= bdm_pkg::B2_LO) && (a <= bdm_pkg::B2_HI);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : ram_in_bank

  function automatic logic [bdm_pkg::IDX_W-1:0] ram_index(input logic [bdm_pkg::ADDR_W-1:0] a,
                                                          input logic [bdm_pkg::BANK_W-1:0] b);
    logic [bdm_pkg::IDX_W-1:0] idx;
    idx = '0;
    case (b)
      2'h0:    idx = {1'b0, a - bdm_pkg::B0_LO};
      2'h1:    idx = bdm_pkg::B1_IDX0 + {1'b0, a - bdm_pkg::B1_LO};
      2'h2:    idx = bdm_pkg::B2_IDX0 + {1'b0, a - bdm_pkg::B2_LO};
      default: idx = '0;
    endcase
    return idx;
  endfunction : ram_index

  logic [bdm_pkg::DATA_W-1:0] mem_q [DEPTH];

  wire access  = MEM_RD_IN | MEM_WR_IN;
  wire in_sfr  = (MEM_ADDR_IN >= bdm_pkg::MEM_BASE) && (MEM_ADDR_IN < bdm_pkg::SFR_END);
  wire is_nvmc = (MEM_ADDR_IN == bdm_pkg::NVMC_ADDR);
  // the sfr decode never looks at the bank pointer
  wire sfr_hit = in_sfr && !is_nvmc;
  // 40H outside bank 1 selects nothing, so it reads as zero and drops writes
  wire nvm_hit = is_nvmc && (BANK_PTR_IN == bdm_pkg::NVMC_BANK);
  wire ram_hit = ram_in_bank(MEM_ADDR_IN, BANK_PTR_IN);
  wire [bdm_pkg::IDX_W-1:0] ram_idx = ram_index(MEM_ADDR_IN, BANK_PTR_IN);
  wire ram_wr  = MEM_WR_IN && ram_hit;

  logic                       sfr_sel_q, nvm_sel_q, sfr_wr_q, rd1_q, ram_rd1_q, fwd_rd1_q;
  logic [bdm_pkg::ADDR_W-1:0] sfr_addr_q;
  logic [bdm_pkg::DATA_W-1:0] sfr_wdata_q, ram_data_q, rdata_q;
  logic                       rvalid_q;

  // unmapped reads fall through to zero and unmapped writes touch nothing
  wire [bdm_pkg::DATA_W-1:0] rdata_d = ram_rd1_q ? ram_data_q :
                                       fwd_rd1_q ? SFR_RDATA_IN : bdm_pkg::READ_ZERO;

  // ram is volatile and left unreset; its contents are undefined until written
  // a read and a write of the same byte in one cycle return the old byte
  always_ff @(posedge CLK_IN) begin
    if (ram_wr) begin
      mem_q[ram_idx] <= MEM_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sfr_sel_q   <= 1'b0;
      nvm_sel_q   <= 1'b0;
      sfr_wr_q    <= 1'b0;
      sfr_addr_q  <= 8'h00;
      sfr_wdata_q <= 8'h00;
      rd1_q       <= 1'b0;
      ram_rd1_q   <= 1'b0;
      fwd_rd1_q   <= 1'b0;
      ram_data_q  <= 8'h00;
    end else begin
      sfr_sel_q   <= access && sfr_hit;
      nvm_sel_q   <= access && nvm_hit;
      sfr_wr_q    <= MEM_WR_IN && (sfr_hit || nvm_hit);
      // address and write data copy every cycle; only the selects qualify them
      sfr_addr_q  <= MEM_ADDR_IN;
      sfr_wdata_q <= MEM_WDATA_IN;
      rd1_q       <= MEM_RD_IN;
      ram_rd1_q   <= MEM_RD_IN && ram_hit;
      fwd_rd1_q   <= MEM_RD_IN && (sfr_hit || nvm_hit);
      ram_data_q  <= ram_hit ? mem_q[ram_idx] : bdm_pkg::READ_ZERO;
    end
  end

  // second stage lines up ram, sfr and unmapped reads at one fixed latency,
  // which costs a cycle on ram reads but keeps the core's read timing uniform
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rd1_q ? rdata_d : bdm_pkg::READ_ZERO;
      rvalid_q <= rd1_q;
    end
  end

  assign RDATA_OUT       = rdata_q;
  assign RDATA_VALID_OUT = rvalid_q;
  assign SFR_SEL_OUT     = sfr_sel_q;
  assign NVMC_SEL_OUT    = nvm_sel_q;
  assign SFR_WR_OUT      = sfr_wr_q;
  assign SFR_ADDR_OUT    = sfr_addr_q;
  assign SFR_WDATA_OUT   = sfr_wdata_q;

  sequence s_ram_write;
    MEM_WR_IN && !MEM_RD_IN && ram_hit;
  endsequence
  sequence s_same_read;
    MEM_RD_IN && !MEM_WR_IN && ram_hit && (ram_idx == $past(ram_idx));
  endsequence

  AST_RAM_HOLDS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_ram_write ##1 s_same_read) |-> ##2 (RDATA_VALID_OUT && RDATA_OUT == $past(MEM_WDATA_IN, 3)))
    else $error("ram read does not return the byte just written");

  AST_SFR_ALL_BANKS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (access && in_sfr && !is_nvmc) |=> (SFR_SEL_OUT && SFR_ADDR_OUT == $past(MEM_ADDR_IN)))
    else $error("sfr access not forwarded in this bank");

  AST_NVMC_OTHER_BANK: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (access && is_nvmc && BANK_PTR_IN != 2'h1) |=> (!NVMC_SEL_OUT && !SFR_SEL_OUT))
    else $error("nvm control reached outside bank 1");

  AST_NVMC_BANK1: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (access && is_nvmc && BANK_PTR_IN == 2'h1) |=> (NVMC_SEL_OUT && !SFR_SEL_OUT))
    else $error("nvm control not selected in bank 1");

  AST_BANK1_INDEX: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ram_hit && BANK_PTR_IN == 2'h1) |-> (ram_idx >= 9'h0a0 && ram_idx < 9'h120))
    else $error("bank 1 access lands outside its ram slice");

  AST_BASE_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_RD_IN && MEM_ADDR_IN == 8'h00) |=> (SFR_SEL_OUT && SFR_ADDR_OUT == 8'h00))
    else $error("address 00H is not the first mapped location");

  AST_SMALL_MAP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_ADDR_IN >= 8'h60) |-> (ram_hit == ((BANK_PTR_IN == 2'h0) ||
      (BANK_PTR_IN == 2'h1 && MEM_ADDR_IN >= 8'h80) ||
      (VARIANT_LARGE && BANK_PTR_IN == 2'h2 && MEM_ADDR_IN >= 8'h80 && MEM_ADDR_IN <= 8'hdf))))
    else $error("ram window of bank 0 or 1 is wrong");

  AST_LARGE_BANK2: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (BANK_PTR_IN == 2'h2 && MEM_ADDR_IN >= 8'h80 && MEM_ADDR_IN <= 8'hdf)
      |-> (ram_hit == VARIANT_LARGE && (!ram_hit || ram_idx >= 9'h120)))
    else $error("bank 2 ram window does not match the variant");

  AST_NO_PROTECT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_WR_IN && ram_hit) |=> (mem_q[$past(ram_idx)] == $past(MEM_WDATA_IN)))
    else $error("ram write was not stored");

  AST_UNMAPPED_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_RD_IN && !in_sfr && !ram_hit) |-> ##2 (RDATA_VALID_OUT && RDATA_OUT == 8'h00))
    else $error("unmapped read did not return zero");

  AST_UNMAPPED_NOSEL: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_WR_IN && !sfr_hit && !nvm_hit) |=> (!SFR_WR_OUT && !NVMC_SEL_OUT))
    else $error("unmapped write reached a register");

  // forwarded reads: select in the next cycle, answer on the read port one cycle later
  sequence s_sfr_read;
    MEM_RD_IN && !MEM_WR_IN && sfr_hit;
  endsequence
  sequence s_fwd_answer;
    SFR_SEL_OUT && !NVMC_SEL_OUT && !SFR_WR_OUT;
  endsequence

  AST_SFR_READ_FWD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s_sfr_read |=> (s_fwd_answer ##1 (RDATA_VALID_OUT && RDATA_OUT == $past(SFR_RDATA_IN))))
    else $error("sfr read data not returned one cycle after the select");

  AST_NVMC_READ_FWD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_RD_IN && !MEM_WR_IN && nvm_hit) |=> (NVMC_SEL_OUT ##1
      (RDATA_VALID_OUT && RDATA_OUT == $past(SFR_RDATA_IN))))
    else $error("nvm control read data not returned");

  AST_SFR_WDATA: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_WR_IN && sfr_hit) |=> (SFR_SEL_OUT && SFR_WR_OUT &&
      SFR_WDATA_OUT == $past(MEM_WDATA_IN)))
    else $error("sfr write not forwarded with its data");

  AST_NVMC_WRITE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_WR_IN && nvm_hit) |=> (NVMC_SEL_OUT && SFR_WR_OUT &&
      SFR_WDATA_OUT == $past(MEM_WDATA_IN)))
    else $error("nvm control write not forwarded with its data");

  AST_READ_LATENCY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    MEM_RD_IN |-> ##2 RDATA_VALID_OUT)
    else $error("read answer not two cycles after the request");

  AST_READ_IDLE_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!MEM_RD_IN) |-> ##2 (!RDATA_VALID_OUT && RDATA_OUT == 8'h00))
    else $error("read port not quiet without a read");

  AST_RAM_WR_LOCAL: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (MEM_WR_IN && ram_hit) |=> (!SFR_SEL_OUT && !NVMC_SEL_OUT && !SFR_WR_OUT))
    else $error("ram write leaked onto the sfr side");

  AST_BANK0_INDEX: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ram_hit && BANK_PTR_IN == 2'h0) |-> (ram_idx < 9'h0a0))
    else $error("bank 0 access lands outside its ram slice");

  AST_RAM_DEPTH: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ram_hit |-> (ram_idx < DEPTH))
    else $error("ram index beyond the variant depth");

  AST_BANK3_NO_RAM: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (BANK_PTR_IN == 2'h3) |-> !ram_hit)
    else $error("bank 3 reached ram");
endmodule : bdm_decoder
`default_nettype wire

/* rtl/bdm_pkg.sv */
// Purpose: shared constants of the banked data memory decoder
// Assumes: 8-bit data memory addresses, bank pointer taken from the core
// Notes:   ram indices pack bank 0, bank 1 and bank 2 one after another
package bdm_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned IDX_W       = 9;
  localparam int unsigned DEPTH_SMALL = 288;
  localparam int unsigned DEPTH_LARGE = 384;

  localparam logic [ADDR_W-1:0] MEM_BASE   = 8'h00;
  localparam logic [ADDR_W-1:0] SFR_END    = 8'h60;
  localparam logic [ADDR_W-1:0] NVMC_ADDR  = 8'h40;
  localparam logic [BANK_W-1:0] NVMC_BANK  = 2'h1;
  localparam logic [ADDR_W-1:0] B0_LO      = 8'h60;
  localparam logic [ADDR_W-1:0] B0_HI      = 8'hff;
  localparam logic [ADDR_W-1:0] B1_LO      = 8'h80;
  localparam logic [ADDR_W-1:0] B1_HI      = 8'hff;
  localparam logic [ADDR_W-1:0] B2_LO      = 8'h80;
  localparam logic [ADDR_W-1:0] B2_HI      = 8'hdf;
  localparam logic [IDX_W-1:0]  B1_IDX0    = 9'h0a0;
  localparam logic [IDX_W-1:0]  B2_IDX0    = 9'h120;
  localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;
endpackage : bdm_pkg

/* dv/bdm_sfr_model.sv */
// Purpose: behavioural special-function block answering forwarded accesses
// Assumes: answers in the same cycle as the select, writes land on the next edge
// Notes:   slot 96 is the nvm control register; idle bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module bdm_sfr_model (
  input  wire logic       clk_in,
  input  wire logic       sfr_sel_in,
  input  wire logic       nvmc_sel_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out
);
  logic [7:0] regs_q [0:96];
  logic [7:0] last_q;
  wire  [6:0] idx = nvmc_sel_in ? 7'h60 : sfr_addr_in[6:0];
  wire        hit = sfr_sel_in | nvmc_sel_in;
  initial begin
    for (int i = 0; i < 97; i++) regs_q[i] = 8'(i) ^ 8'ha5;
    last_q = 8'h00;
  end
  // a released bus must not look like a valid answer
  assign sfr_rdata_out = hit ? regs_q[idx] : ~last_q;
  always @(posedge clk_in) begin
    if (hit && sfr_wr_in) regs_q[idx] <= sfr_wdata_in;
    last_q <= sfr_rdata_out;
  end
endmodule : bdm_sfr_model
`default_nettype wire

/* dv/tb_banked_data_memory_decoder.sv */
// Purpose: self-checking bench of the banked data memory decoder, both variants side by side
// Assumes: one access at a time except the back-to-back case
// Notes:   rows hold bank, address, write flag, data, expected {nvm select, sfr select}
`timescale 1ns/1ps
`default_nettype none
module tb_banked_data_memory_decoder;
  typedef struct packed {logic [1:0] b; logic [7:0] a; logic wr; logic [7:0] d;
                         logic [1:0] sel;} bdm_row_t;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] srd, rdata, s_addr, s_wdata;
  logic       valid, s_sel, n_sel, s_wr;
  logic [7:0] rdata_s;
  logic       valid_s;
  int         n_errors = 0;
  int         check_count = 0;
  bdm_row_t   rows [23];
  always #5 clk = ~clk;
  bdm_decoder #(.VARIANT_LARGE(1'b1)) dut (.CLK_IN(clk), .RST_N_IN(rst_n), .MEM_ADDR_IN(addr),
    .BANK_PTR_IN(bank), .MEM_RD_IN(rd), .MEM_WR_IN(wr), .MEM_WDATA_IN(wdata),
    .SFR_RDATA_IN(srd), .RDATA_OUT(rdata), .RDATA_VALID_OUT(valid), .SFR_SEL_OUT(s_sel),
    .NVMC_SEL_OUT(n_sel), .SFR_WR_OUT(s_wr), .SFR_ADDR_OUT(s_addr), .SFR_WDATA_OUT(s_wdata));
  bdm_sfr_model sfr (.clk_in(clk), .sfr_sel_in(s_sel), .nvmc_sel_in(n_sel), .sfr_wr_in(s_wr),
    .sfr_addr_in(s_addr), .sfr_wdata_in(s_wdata), .sfr_rdata_out(srd));
  // small variant sees the same requests; its selects match the large one, so srd serves both
  bdm_decoder #(.VARIANT_LARGE(1'b0)) dut_small (.CLK_IN(clk), .RST_N_IN(rst_n),
    .MEM_ADDR_IN(addr), .BANK_PTR_IN(bank), .MEM_RD_IN(rd), .MEM_WR_IN(wr),
    .MEM_WDATA_IN(wdata), .SFR_RDATA_IN(srd), .RDATA_OUT(rdata_s), .RDATA_VALID_OUT(valid_s),
    .SFR_SEL_OUT(), .NVMC_SEL_OUT(), .SFR_WR_OUT(), .SFR_ADDR_OUT(), .SFR_WDATA_OUT());
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic acc(input bdm_row_t r);
    logic [7:0] small_exp;
    // the small variant has no bank 2 ram, so those reads fall to zero
    small_exp = (r.wr || (r.b == 2'h2 && r.a >= 8'h80)) ? 8'h00 : r.d;
    bank  = r.b;
    addr  = r.a;
    wr    = r.wr;
    rd    = !r.wr;
    wdata = r.d;
    @(posedge clk);
    #1;
    rd = 1'b0;
    wr = 1'b0;
    chk("sfr_sel", {7'h0, r.sel[0]}, {7'h0, s_sel});
    chk("nvmc_sel", {7'h0, r.sel[1]}, {7'h0, n_sel});
    chk("sfr_wr", {7'h0, r.wr && (r.sel != 2'h0)}, {7'h0, s_wr});
    if (r.sel != 2'h0) chk("sfr_addr", r.a, s_addr);
    if (r.sel != 2'h0 && r.wr) chk("sfr_wdata", r.d, s_wdata);
    @(posedge clk);
    #1;
    chk("valid", {7'h0, !r.wr}, {7'h0, valid});
    chk("rdata", r.wr ? 8'h00 : r.d, rdata);
    chk("valid_small", {7'h0, !r.wr}, {7'h0, valid_s});
    chk("rdata_small", small_exp, rdata_s);
  endtask : acc
  initial begin
    rows = '{'{2'h0,8'h60,1'b1,8'h5a,2'h0}, '{2'h1,8'h80,1'b1,8'hc3,2'h0},
      '{2'h1,8'hff,1'b1,8'h33,2'h0}, '{2'h2,8'hdf,1'b1,8'h7e,2'h0}, '{2'h2,8'he0,1'b1,8'h99,2'h0},
      '{2'h3,8'h80,1'b1,8'h11,2'h0}, '{2'h0,8'h05,1'b1,8'h77,2'h1}, '{2'h1,8'h40,1'b1,8'h0f,2'h2},
      '{2'h0,8'h40,1'b1,8'h55,2'h0}, '{2'h0,8'h60,1'b0,8'h5a,2'h0}, '{2'h1,8'h80,1'b0,8'hc3,2'h0},
      '{2'h1,8'hff,1'b0,8'h33,2'h0}, '{2'h2,8'hdf,1'b0,8'h7e,2'h0}, '{2'h2,8'he0,1'b0,8'h00,2'h0},
      '{2'h3,8'h80,1'b0,8'h00,2'h0}, '{2'h1,8'h60,1'b0,8'h00,2'h0}, '{2'h3,8'h05,1'b0,8'h77,2'h1},
      '{2'h0,8'h5f,1'b0,8'hfa,2'h1}, '{2'h1,8'h40,1'b0,8'h0f,2'h2}, '{2'h2,8'h40,1'b0,8'h00,2'h0},
      '{2'h0,8'h40,1'b0,8'h00,2'h0}, '{2'h2,8'h00,1'b0,8'ha5,2'h1}, '{2'h3,8'hd0,1'b0,8'h00,2'h0}};
    repeat (2) @(posedge clk);
    #1;
    chk("valid_in_reset", 8'h00, {7'h0, valid});
    rst_n = 1'b1;
    foreach (rows[i]) acc(rows[i]);
    $display("table test done");
    // write then two pipelined reads, the first of the fresh byte
    bank = 2'h0; addr = 8'h61; wdata = 8'ha1; wr = 1'b1;
    @(posedge clk); #1;
    wr = 1'b0; rd = 1'b1;
    @(posedge clk); #1;
    addr = 8'h60;
    @(posedge clk); #1;
    rd = 1'b0;
    chk("b2b_first", 8'ha1, rdata);
    @(posedge clk); #1;
    chk("b2b_second", 8'h5a, rdata);
    chk("b2b_valid", 8'h01, {7'h0, valid});
    $display("back to back test done");
    rst_n = 1'b0;
    @(posedge clk); #1;
    chk("sel_in_reset", 8'h00, {6'h0, n_sel, s_sel});
    @(posedge clk); #1;
    rst_n = 1'b1;
    acc('{2'h3, 8'h05, 1'b0, 8'h77, 2'h1});
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : tb_banked_data_memory_decoder
`default_nettype wire
